// file: shared/srn_defs.svh
// Constants for the serial rate negotiation block
`ifndef SRN_DEFS_SVH
`define SRN_DEFS_SVH

// ----------------------------------------------------------------------------
// Framing bytes and packet identifiers
// ----------------------------------------------------------------------------
`define SRN_FRAME_DELIMITER_BYTE  8'h10
`define SRN_FRAME_END_BYTE        8'h03
`define SRN_ID_REQUEST_DATA       8'h1C
`define SRN_ID_ACKNOWLEDGE        8'h06
`define SRN_ID_RATE_REQUEST       8'h30
`define SRN_ID_RATE_ACCEPT        8'h31
`define SRN_ID_COMMAND            8'h0A
`define SRN_PING_COMMAND_CODE     8'h3A

// ----------------------------------------------------------------------------
// Rates and timing
// ----------------------------------------------------------------------------
`define SRN_FALLBACK_RATE         32'h0000_2580
`define SRN_CLK_HZ                100000000
`define SRN_PROOF_TIME_MS         2000
`define SRN_PROOF_CYCLES          (`SRN_CLK_HZ / 1000 * `SRN_PROOF_TIME_MS)
`define SRN_MAX_PAYLOAD           8'h04
`define SRN_RATE_BYTES            3'h4
`define SRN_RATE_TABLE_SIZE       8

`endif

// file: shared/srn_pkg.sv
// Types for the serial rate negotiation block
package srn_pkg;

	typedef enum logic [6:0] {
		SRN_RX_IDLE  = 7'h01,
		SRN_RX_ID    = 7'h02,
		SRN_RX_SIZE  = 7'h04,
		SRN_RX_DATA  = 7'h08,
		SRN_RX_SUM   = 7'h10,
		SRN_RX_DLE   = 7'h20,
		SRN_RX_END   = 7'h40
	} srn_rx_type;

	typedef enum logic [5:0] {
		SRN_TX_IDLE  = 6'h01,
		SRN_TX_HEAD  = 6'h02,
		SRN_TX_BODY  = 6'h04,
		SRN_TX_SUM   = 6'h08,
		SRN_TX_DLE   = 6'h10,
		SRN_TX_END   = 6'h20
	} srn_tx_type;

	typedef enum logic [3:0] {
		SRN_NEG_OPEN    = 4'h1,
		SRN_NEG_ACCEPTED = 4'h2,
		SRN_NEG_PROVING = 4'h4,
		SRN_NEG_PROVEN1 = 4'h8
	} srn_neg_type;

endpackage

// file: src/srn_top.sv
// Serial rate negotiation command interpreter, device end
`timescale 1ns/1ps
`default_nettype none
`include "srn_defs.svh"

module srn_top
(
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	input  wire logic        POWER_ON,
	input  wire logic [7:0]  RX_DATA,
	input  wire logic        RX_VALID,
	output logic [7:0]       TX_DATA,
	output logic             TX_VALID,
	input  wire logic        TX_READY,
	input  wire logic        BINARY_MODE_CMD,
	input  wire logic        NMEA_MODE_CMD,
	input  wire logic        CFG_UPLOAD,
	input  wire logic        CFG_BINARY,
	input  wire logic        NV_BINARY,
	input  wire logic [31:0] NV_DEFAULT_RATE,
	output logic             NV_WRITE,
	output logic             NV_WRITE_BINARY,
	output logic [31:0]      LINK_RATE,
	output logic             LINK_RATE_LOAD,
	output logic             REQUESTS_OFF,
	output logic             BINARY_MODE,
	output logic             PACKET_ERROR
);

	// ------------------------------------------------------------------------
	// Achievable rates, as the baud divider really makes them
	// ------------------------------------------------------------------------
	logic [31:0] actual_rate  [`SRN_RATE_TABLE_SIZE];
	// All within five percent of a standard rate
	assign actual_rate = '{32'h0000_12C0, 32'h0000_2580, 32'h0000_4B00, 32'h0000_95D9,
		32'h0000_E0B3, 32'h0001_C166, 32'h0002_5800, 32'h0003_82CC};

	// ------------------------------------------------------------------------
	// Receive framing
	// ------------------------------------------------------------------------
	srn_pkg::srn_rx_type rx_q;
	logic [7:0]  rx_id_q;
	logic [7:0]  rx_size_q;
	logic [7:0]  rx_cnt_q;
	logic [7:0]  rx_sum_q;
	logic [31:0] rx_word_q;
	logic        rx_stuff_q;
	logic        pkt_done;
	logic        byte_in;
	logic        is_dle;

	assign is_dle  = RX_DATA == `SRN_FRAME_DELIMITER_BYTE;
	// A doubled delimiter inside the frame stands for one data byte
	assign byte_in = RX_VALID && !(is_dle && !rx_stuff_q && rx_q != srn_pkg::SRN_RX_IDLE
		&& rx_q != srn_pkg::SRN_RX_DLE && rx_q != srn_pkg::SRN_RX_END);

	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
			rx_stuff_q <= 1'b0;
		else if (RX_VALID && rx_q != srn_pkg::SRN_RX_IDLE && rx_q != srn_pkg::SRN_RX_DLE
			&& rx_q != srn_pkg::SRN_RX_END)
			rx_stuff_q <= is_dle && !rx_stuff_q;
	end

	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			rx_q      <= srn_pkg::SRN_RX_IDLE;
			rx_id_q   <= 8'h00;
			rx_size_q <= 8'h00;
			rx_cnt_q  <= 8'h00;
			rx_sum_q  <= 8'h00;
			rx_word_q <= 32'h0000_0000;
		end
		else if (byte_in)
		begin
			case (rx_q)
				srn_pkg::SRN_RX_IDLE:
					if (is_dle)
						rx_q <= srn_pkg::SRN_RX_ID;
				srn_pkg::SRN_RX_ID:
				begin
					rx_id_q  <= RX_DATA;
					rx_sum_q <= RX_DATA;
					rx_q     <= srn_pkg::SRN_RX_SIZE;
				end
				srn_pkg::SRN_RX_SIZE:
				begin
					rx_size_q <= RX_DATA;
					rx_cnt_q  <= 8'h00;
					rx_word_q <= 32'h0000_0000;
					rx_sum_q  <= rx_sum_q + RX_DATA;
					rx_q      <= (RX_DATA == 8'h00) ? srn_pkg::SRN_RX_SUM : srn_pkg::SRN_RX_DATA;
				end
				srn_pkg::SRN_RX_DATA:
				begin
					// Least significant byte first
					if (rx_cnt_q < `SRN_MAX_PAYLOAD)
						rx_word_q[rx_cnt_q[1:0]*8 +: 8] <= RX_DATA;
					rx_sum_q <= rx_sum_q + RX_DATA;
					rx_cnt_q <= rx_cnt_q + 8'h01;
					if (rx_cnt_q + 8'h01 == rx_size_q)
						rx_q <= srn_pkg::SRN_RX_SUM;
				end
				srn_pkg::SRN_RX_SUM:
				begin
					rx_sum_q <= rx_sum_q + RX_DATA;
					rx_q     <= srn_pkg::SRN_RX_DLE;
				end
				srn_pkg::SRN_RX_DLE:
					rx_q <= is_dle ? srn_pkg::SRN_RX_END : srn_pkg::SRN_RX_IDLE;
				srn_pkg::SRN_RX_END:
					rx_q <= srn_pkg::SRN_RX_IDLE;
				default:
					rx_q <= srn_pkg::SRN_RX_IDLE;
			endcase
		end
	end

	// Good frame: end byte seen and enclosed bytes sum to zero
	assign pkt_done = byte_in && rx_q == srn_pkg::SRN_RX_END
		&& RX_DATA == `SRN_FRAME_END_BYTE && rx_sum_q == 8'h00;

	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
			PACKET_ERROR <= 1'b0;
		else
			PACKET_ERROR <= byte_in && rx_q == srn_pkg::SRN_RX_END
				&& !(RX_DATA == `SRN_FRAME_END_BYTE && rx_sum_q == 8'h00);
	end

	// ------------------------------------------------------------------------
	// Closest achievable rate, highest wins a tie
	// ------------------------------------------------------------------------
	logic [31:0] best_rate;
	logic [31:0] best_err;
	logic [31:0] diff;
	always_comb
	begin
		best_rate = actual_rate[0];
		best_err  = 32'hFFFF_FFFF;
		diff      = 32'h0000_0000;
		for (int i = 0; i < `SRN_RATE_TABLE_SIZE; i++)
		begin
			diff = (actual_rate[i] > rx_word_q) ? actual_rate[i] - rx_word_q
				: rx_word_q - actual_rate[i];
			if (diff <= best_err)
			begin
				best_err  = diff;
				best_rate = actual_rate[i];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Negotiation
	// ------------------------------------------------------------------------
	srn_pkg::srn_neg_type neg_q;
	logic [31:0] offer_q;
	logic [31:0] timer_q;
	logic        reply_q;
	logic [7:0]  reply_id_q;
	logic [7:0]  reply_len_q;
	logic [31:0] reply_word_q;
	logic        tx_busy;
	logic        is_ping;

	assign is_ping = pkt_done && rx_id_q == `SRN_ID_COMMAND && rx_size_q == 8'h02
		&& rx_word_q[7:0] == `SRN_PING_COMMAND_CODE;

	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			reply_q      <= 1'b0;
			reply_id_q   <= 8'h00;
			reply_len_q  <= 8'h00;
			reply_word_q <= 32'h0000_0000;
		end
		else if (pkt_done && rx_id_q == `SRN_ID_REQUEST_DATA && rx_word_q[15:0] == 16'h0000)
		begin
			reply_q      <= 1'b1;
			reply_id_q   <= `SRN_ID_ACKNOWLEDGE;
			reply_len_q  <= 8'h02;
			reply_word_q <= {24'h00_0000, `SRN_ID_REQUEST_DATA};
		end
		else if (pkt_done && rx_id_q == `SRN_ID_RATE_REQUEST && REQUESTS_OFF)
		begin
			reply_q      <= 1'b1;
			reply_id_q   <= `SRN_ID_RATE_ACCEPT;
			reply_len_q  <= 8'h04;
			reply_word_q <= best_rate;
		end
		else if (is_ping && (neg_q == srn_pkg::SRN_NEG_PROVING
			|| neg_q == srn_pkg::SRN_NEG_PROVEN1))
		begin
			reply_q      <= 1'b1;
			reply_id_q   <= `SRN_ID_ACKNOWLEDGE;
			reply_len_q  <= 8'h02;
			reply_word_q <= {24'h00_0000, `SRN_ID_COMMAND};
		end
		else if (!tx_busy)
			reply_q <= 1'b0;
	end

	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
			REQUESTS_OFF <= 1'b0;
		else if (pkt_done && rx_id_q == `SRN_ID_REQUEST_DATA)
			REQUESTS_OFF <= rx_word_q[15:0] == 16'h0000;
	end

	// Timer only counts while proving; nothing is written to nonvolatile store
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			neg_q          <= srn_pkg::SRN_NEG_OPEN;
			offer_q        <= 32'h0000_0000;
			timer_q        <= 32'h0000_0000;
			LINK_RATE      <= `SRN_FALLBACK_RATE;
			LINK_RATE_LOAD <= 1'b0;
		end
		else
		begin
			LINK_RATE_LOAD <= 1'b0;
			if (POWER_ON)
			begin
				neg_q          <= srn_pkg::SRN_NEG_OPEN;
				LINK_RATE      <= NV_DEFAULT_RATE;
				LINK_RATE_LOAD <= 1'b1;
			end
			else
			case (neg_q)
				srn_pkg::SRN_NEG_OPEN, srn_pkg::SRN_NEG_ACCEPTED:
					// A later request replaces the offer the host would accept
					if (pkt_done && rx_id_q == `SRN_ID_RATE_REQUEST && REQUESTS_OFF)
					begin
						offer_q <= best_rate;
						neg_q   <= srn_pkg::SRN_NEG_ACCEPTED;
					end
					// Host ack carries the rate accept id; switch at once
					else if (neg_q == srn_pkg::SRN_NEG_ACCEPTED && pkt_done
						&& rx_id_q == `SRN_ID_ACKNOWLEDGE
						&& rx_word_q[7:0] == `SRN_ID_RATE_ACCEPT)
					begin
						LINK_RATE      <= offer_q;
						LINK_RATE_LOAD <= 1'b1;
						timer_q        <= 32'h0000_0000;
						neg_q          <= srn_pkg::SRN_NEG_PROVING;
					end
				srn_pkg::SRN_NEG_PROVING, srn_pkg::SRN_NEG_PROVEN1:
				begin
					timer_q <= timer_q + 32'h0000_0001;
					if (is_ping && neg_q == srn_pkg::SRN_NEG_PROVEN1)
						neg_q <= srn_pkg::SRN_NEG_OPEN;
					else if (is_ping)
						neg_q <= srn_pkg::SRN_NEG_PROVEN1;
					else if (timer_q >= 32'(`SRN_PROOF_CYCLES - 1))
					begin
						LINK_RATE      <= `SRN_FALLBACK_RATE;
						LINK_RATE_LOAD <= 1'b1;
						neg_q          <= srn_pkg::SRN_NEG_OPEN;
					end
				end
				default:
					neg_q <= srn_pkg::SRN_NEG_OPEN;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Output mode: command is volatile, upload is persistent
	// ------------------------------------------------------------------------
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
			BINARY_MODE <= 1'b0;
		else if (POWER_ON)
			BINARY_MODE <= NV_BINARY;
		else if (CFG_UPLOAD)
			BINARY_MODE <= CFG_BINARY;
		else if (BINARY_MODE_CMD)
			BINARY_MODE <= 1'b1;
		else if (NMEA_MODE_CMD)
			BINARY_MODE <= 1'b0;
	end

	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			NV_WRITE        <= 1'b0;
			NV_WRITE_BINARY <= 1'b0;
		end
		else
		begin
			NV_WRITE <= CFG_UPLOAD;
			if (CFG_UPLOAD)
				NV_WRITE_BINARY <= CFG_BINARY;
		end
	end

	// ------------------------------------------------------------------------
	// Transmit framing
	// ------------------------------------------------------------------------
	srn_pkg::srn_tx_type tx_q;
	logic [7:0] tx_cnt_q;
	logic [7:0] tx_sum_q;
	logic       tx_stuff_q;
	logic [7:0] tx_byte;

	// Last byte still waiting counts as busy, or a new reply would be lost
	assign tx_busy = tx_q != srn_pkg::SRN_TX_IDLE || (TX_VALID && !TX_READY);

	always_comb
	begin
		case (tx_q)
			srn_pkg::SRN_TX_HEAD: tx_byte = (tx_cnt_q == 8'h00) ? reply_id_q : reply_len_q;
			srn_pkg::SRN_TX_BODY: tx_byte = reply_word_q[tx_cnt_q[1:0]*8 +: 8];
			srn_pkg::SRN_TX_SUM:  tx_byte = 8'h00 - tx_sum_q;
			srn_pkg::SRN_TX_END:  tx_byte = `SRN_FRAME_END_BYTE;
			default:              tx_byte = `SRN_FRAME_DELIMITER_BYTE;
		endcase
	end

	// Data bytes equal to the delimiter are sent twice
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			tx_q       <= srn_pkg::SRN_TX_IDLE;
			tx_cnt_q   <= 8'h00;
			tx_sum_q   <= 8'h00;
			tx_stuff_q <= 1'b0;
			TX_DATA    <= 8'h00;
			TX_VALID   <= 1'b0;
		end
		else if (TX_VALID && !TX_READY)
			TX_VALID <= 1'b1;
		else if (tx_q == srn_pkg::SRN_TX_IDLE)
		begin
			TX_VALID <= 1'b0;
			if (reply_q)
			begin
				TX_DATA  <= `SRN_FRAME_DELIMITER_BYTE;
				TX_VALID <= 1'b1;
				tx_q     <= srn_pkg::SRN_TX_HEAD;
				tx_cnt_q <= 8'h00;
				tx_sum_q <= 8'h00;
			end
		end
		else
		begin
			TX_DATA  <= tx_byte;
			TX_VALID <= 1'b1;
			if (tx_byte == `SRN_FRAME_DELIMITER_BYTE && !tx_stuff_q
				&& tx_q != srn_pkg::SRN_TX_DLE)
				tx_stuff_q <= 1'b1;
			else
			begin
				tx_stuff_q <= 1'b0;
				case (tx_q)
					srn_pkg::SRN_TX_HEAD:
					begin
						tx_sum_q <= tx_sum_q + tx_byte;
						tx_cnt_q <= (tx_cnt_q == 8'h00) ? 8'h01 : 8'h00;
						if (tx_cnt_q != 8'h00)
							tx_q <= srn_pkg::SRN_TX_BODY;
					end
					srn_pkg::SRN_TX_BODY:
					begin
						tx_sum_q <= tx_sum_q + tx_byte;
						tx_cnt_q <= tx_cnt_q + 8'h01;
						if (tx_cnt_q + 8'h01 == reply_len_q)
							tx_q <= srn_pkg::SRN_TX_SUM;
					end
					srn_pkg::SRN_TX_SUM: tx_q <= srn_pkg::SRN_TX_DLE;
					srn_pkg::SRN_TX_DLE: tx_q <= srn_pkg::SRN_TX_END;
					default:             tx_q <= srn_pkg::SRN_TX_IDLE;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// file: test/srn_host_model.sv
// Host end of the serial link: sends framed bytes, drains replies
`timescale 1ns/1ps
`default_nettype none
module srn_host
(
	input  wire logic       clk,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic [7:0] got[$];

	initial
	begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
	end

	// ----
	// Reply side, stalls at random like a busy host
	// ----
	always @(posedge clk)
	begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		tx_ready <= ($urandom_range(0, 3) != 0);
	end

	// ----
	// Send side, gaps between bytes
	// ----
	task automatic send_frame(input logic [7:0] f[$]);
		foreach (f[i])
		begin
			@(posedge clk);
			rx_data <= f[i];
			rx_valid <= 1'b1;
			@(posedge clk);
			rx_valid <= 1'b0;
			// Stale byte must not look valid
			rx_data <= ~f[i];
			repeat ($urandom_range(0, 2)) @(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// file: test/srn_top_chk.sv
// Port assertions for the rate negotiation block
`timescale 1ns/1ps
`default_nettype none
module srn_top_chk
(
	input wire logic        MCLK,
	input wire logic        RST_N,
	input wire logic        POWER_ON,
	input wire logic        BINARY_MODE_CMD,
	input wire logic        NMEA_MODE_CMD,
	input wire logic        CFG_UPLOAD,
	input wire logic        CFG_BINARY,
	input wire logic        NV_BINARY,
	input wire logic [7:0]  TX_DATA,
	input wire logic        TX_VALID,
	input wire logic        TX_READY,
	input wire logic        NV_WRITE,
	input wire logic        NV_WRITE_BINARY,
	input wire logic [31:0] LINK_RATE,
	input wire logic        LINK_RATE_LOAD,
	input wire logic        BINARY_MODE
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	AST_RST_RATE: assert property ($rose(RST_N) |-> LINK_RATE == 32'h0000_2580 && !TX_VALID)
		else $error("link rate not at fallback after reset");
	AST_TX_HOLD: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
		else $error("reply byte dropped before taken");
	AST_RATE_LOAD: assert property ($changed(LINK_RATE) |-> LINK_RATE_LOAD)
		else $error("link rate changed without load");
	AST_NV_WRITE: assert property (CFG_UPLOAD |=> NV_WRITE && NV_WRITE_BINARY == $past(CFG_BINARY))
		else $error("upload not written to store");
	AST_NV_ONLY: assert property (NV_WRITE |-> $past(CFG_UPLOAD))
		else $error("store written without upload");
	AST_BIN_CMD: assert property (BINARY_MODE_CMD && !NMEA_MODE_CMD && !CFG_UPLOAD && !POWER_ON |=> BINARY_MODE)
		else $error("binary command not applied");
	AST_NMEA_CMD: assert property (NMEA_MODE_CMD && !BINARY_MODE_CMD && !CFG_UPLOAD && !POWER_ON |=> !BINARY_MODE)
		else $error("text mode command not applied");
	AST_POWER: assert property (POWER_ON && !CFG_UPLOAD && !BINARY_MODE_CMD && !NMEA_MODE_CMD |=> BINARY_MODE == $past(NV_BINARY))
		else $error("power cycle did not restore stored mode");
	AST_UPLOAD: assert property (CFG_UPLOAD && !POWER_ON |=> BINARY_MODE == $past(CFG_BINARY))
		else $error("uploaded mode not in effect");
endmodule

bind srn_top srn_top_chk chk_u (.MCLK(MCLK), .RST_N(RST_N), .POWER_ON(POWER_ON),
	.BINARY_MODE_CMD(BINARY_MODE_CMD), .NMEA_MODE_CMD(NMEA_MODE_CMD), .CFG_UPLOAD(CFG_UPLOAD),
	.CFG_BINARY(CFG_BINARY), .NV_BINARY(NV_BINARY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
	.TX_READY(TX_READY), .NV_WRITE(NV_WRITE), .NV_WRITE_BINARY(NV_WRITE_BINARY),
	.LINK_RATE(LINK_RATE), .LINK_RATE_LOAD(LINK_RATE_LOAD), .BINARY_MODE(BINARY_MODE));
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the rate negotiation block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef logic [7:0] srn_bq_type[$];
	logic        MCLK, RST_N, CFG_BINARY, NV_BINARY;
	logic [3:0]  ev;
	logic [31:0] nv_rate, r;
	logic [7:0]  rx_data, tx_data;
	logic        rx_valid, tx_valid, tx_ready;
	logic [31:0] LINK_RATE;
	logic        REQUESTS_OFF, BINARY_MODE, NV_WRITE_BINARY;
	int          mismatches, num_checks, cyc;
	logic        pkt_err;
	int          err_cnt;
	srn_bq_type  bad;
	logic [31:0] corner[4] = '{32'h0000_1C20, 32'h0000_9600, 32'h0000_0000, 32'h0004_93E0};

	srn_top dut_u (.MCLK(MCLK), .RST_N(RST_N), .POWER_ON(ev[0]), .RX_DATA(rx_data),
		.RX_VALID(rx_valid), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
		.BINARY_MODE_CMD(ev[1]), .NMEA_MODE_CMD(ev[2]), .CFG_UPLOAD(ev[3]),
		.CFG_BINARY(CFG_BINARY), .NV_BINARY(NV_BINARY), .NV_DEFAULT_RATE(nv_rate),
		.NV_WRITE(), .NV_WRITE_BINARY(NV_WRITE_BINARY), .LINK_RATE(LINK_RATE),
		.LINK_RATE_LOAD(), .REQUESTS_OFF(REQUESTS_OFF), .BINARY_MODE(BINARY_MODE),
		.PACKET_ERROR(pkt_err));
	srn_host host_u (.clk(MCLK), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready));

	always #5 MCLK = ~MCLK;

	// ----
	// Expectations
	// ----
	function automatic srn_bq_type frame(logic [7:0] id, int n, logic [31:0] pay);
		srn_bq_type f;
		logic [7:0] b[$];
		logic [7:0] s;
		b = {id, 8'(n)};
		for (int i = 0; i < n; i++)
			b.push_back(pay[8*i +: 8]);
		s = 8'h00;
		foreach (b[i])
			s -= b[i];
		b.push_back(s);
		f = {8'h10};
		foreach (b[i])
		begin
			f.push_back(b[i]);
			if (b[i] == 8'h10)
				f.push_back(8'h10);
		end
		f.push_back(8'h10);
		f.push_back(8'h03);
		return f;
	endfunction

	// Closest achievable rate, higher one on a tie
	function automatic logic [31:0] best(logic [31:0] q);
		logic [31:0] t[8] = '{32'h12C0, 32'h2580, 32'h4B00, 32'h95D9, 32'hE0B3, 32'h1C166,
			32'h25800, 32'h382CC};
		logic [31:0] b, d, bd;
		bd = 32'hFFFF_FFFF;
		foreach (t[i])
		begin
			d = (t[i] > q) ? t[i] - q : q - t[i];
			if (d <= bd)
			begin
				b = t[i];
				bd = d;
			end
		end
		return b;
	endfunction

	// ----
	// Shared tasks
	// ----
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	// Reply of length zero means no reply frame may come back
	task automatic xfer(logic [7:0] id, int n, logic [31:0] pay, logic [7:0] rid, int rn,
		logic [31:0] rpay);
		srn_bq_type e;
		if (rn != 0)
			e = frame(rid, rn, rpay);
		host_u.got.delete();
		host_u.send_frame(frame(id, n, pay));
		for (int t = 0; t < 300 && host_u.got.size() < e.size(); t++)
			@(posedge MCLK);
		repeat (40) @(posedge MCLK);
		check("reply length", host_u.got.size(), e.size());
		foreach (e[i])
			if (i < host_u.got.size())
				check("reply byte", host_u.got[i], e[i]);
	endtask

	task automatic pulse(logic [3:0] m);
		@(posedge MCLK);
		ev <= m;
		@(posedge MCLK);
		ev <= 4'h0;
		@(posedge MCLK);
		#1;
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge MCLK)
	begin
		if (pkt_err === 1'b1)
			err_cnt++;
		cyc++;
		if (cyc == 40000)
		begin
			mismatches++;
			end_sim();
		end
	end

	// ----
	// Main sequence
	// ----
	initial
	begin
		MCLK = 1'b0;
		RST_N = 1'b0;
		ev = 4'h0;
		CFG_BINARY = 1'b0;
		NV_BINARY = 1'b0;
		nv_rate = 32'h0000_4B00;
		void'($urandom(32'hAC9E));
		repeat (12) @(posedge MCLK);
		RST_N <= 1'b1;
		@(posedge MCLK);
		#1;
		check("reset rate", LINK_RATE, 32'h0000_2580);
		check("requests off", REQUESTS_OFF, 1'b0);
		// Corrupt checksum: dropped, flagged, no reply
		bad = frame(8'h1C, 2, 32'h0);
		bad[5] = bad[5] + 8'h01;
		host_u.got.delete();
		host_u.send_frame(bad);
		repeat (40) @(posedge MCLK);
		check("bad frame error", err_cnt, 1);
		check("bad frame reply", host_u.got.size(), 0);
		check("requests after bad frame", REQUESTS_OFF, 1'b0);
		xfer(8'h30, 4, 32'h0000_9600, 8'h00, 0, 0);
		xfer(8'h1C, 2, 32'h0, 8'h06, 2, 32'h1C);
		check("requests off", REQUESTS_OFF, 1'b1);
		xfer(8'h0A, 2, 32'h3A, 8'h00, 0, 0);
		for (int i = 0; i < 10; i++)
		begin
			r = (i < 4) ? corner[i] : $urandom_range(0, 300000);
			xfer(8'h30, 4, r, 8'h31, 4, best(r));
		end
		xfer(8'h0A, 2, 32'h3A, 8'h00, 0, 0);
		xfer(8'h30, 4, 32'h0000_9600, 8'h31, 4, 32'h0000_95D9);
		check("rate before accept", LINK_RATE, 32'h0000_2580);
		xfer(8'h06, 2, 32'h31, 8'h00, 0, 0);
		check("rate after accept", LINK_RATE, 32'h0000_95D9);
		// Host settle time shortened from the nominal pause
		repeat (200) @(posedge MCLK);
		xfer(8'h0A, 2, 32'h3A, 8'h06, 2, 32'h0A);
		xfer(8'h0A, 2, 32'h3A, 8'h06, 2, 32'h0A);
		xfer(8'h0A, 2, 32'h3A, 8'h00, 0, 0);
		check("rate kept", LINK_RATE, 32'h0000_95D9);
		pulse(4'h2);
		check("binary on", BINARY_MODE, 1'b1);
		pulse(4'h4);
		check("binary off", BINARY_MODE, 1'b0);
		pulse(4'h2);
		pulse(4'h1);
		check("mode after power", BINARY_MODE, 1'b0);
		check("rate after power", LINK_RATE, 32'h0000_4B00);
		CFG_BINARY <= 1'b1;
		pulse(4'hC);
		check("upload mode", BINARY_MODE, 1'b1);
		check("stored mode", NV_WRITE_BINARY, 1'b1);
		NV_BINARY <= 1'b1;
		pulse(4'h1);
		check("kept mode", BINARY_MODE, 1'b1);
		check("frame errors", err_cnt, 1);
		end_sim();
	end
endmodule
`default_nettype wire
